// file: ssp_sync_serial_port.sv
// synchronous serial port: fifos, bit-rate generator, frame engines
`timescale 1ns/10ps

// ==========================================================
// generic first-in first-out buffer
module ssp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0]   FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = count_r != FULL_CNT;
  assign out_valid = count_r != '0;
  assign out_data  = mem[rptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_r <= (wptr_r == LAST_PTR) ? '0 : AW'(wptr_r + 1'b1);
      end
      if (pop)
      begin
        rptr_r <= (rptr_r == LAST_PTR) ? '0 : AW'(rptr_r + 1'b1);
      end
      if (push && !pop)
      begin
        count_r <= (AW+1)'(count_r + 1'b1);
      end
      else if (pop && !push)
      begin
        count_r <= (AW+1)'(count_r - 1'b1);
      end
    end
  end
endmodule

// ==========================================================
// serial port top
module ssp_sync_serial_port (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire ssp_pkg::ssp_cfg_s           cfg,
  input  wire logic [3:0]                  interrupt_mask,
  input  wire logic                        timeout_clear,
  input  wire logic                        overrun_clear,
  input  wire logic                        dma_tx_enable,
  input  wire logic                        dma_rx_enable,
  input  wire logic                        wr_valid,
  output logic                             wr_ready,
  input  wire logic [ssp_pkg::DATA_W-1:0]  wr_data,
  output logic                             rd_valid,
  input  wire logic                        rd_ready,
  output logic      [ssp_pkg::DATA_W-1:0]  rd_data,
  output logic      [3:0]                  raw_interrupt_status,
  output logic      [3:0]                  masked_interrupt_status,
  output logic                             irq,
  output logic                             dma_tx_req,
  output logic                             dma_rx_req,
  output logic                             busy,
  input  wire logic                        serial_clock_pin_i,
  output logic                             serial_clock_pin_o,
  output logic                             serial_clock_pin_oe,
  input  wire logic                        frame_select_pin_i,
  output logic                             frame_select_pin_o,
  output logic                             frame_select_pin_oe,
  input  wire logic                        serial_receive_pin,
  output logic                             serial_transmit_pin,
  output logic                             serial_transmit_pin_oe
);
  import ssp_pkg::*;

  ssp_state_s       st_r;
  ssp_state_s       st_nxt;
  logic             tx_valid;
  logic             tx_pop;
  logic [15:0]      tx_word;
  logic             rx_push;
  logic             rx_ready;
  logic [15:0]      rx_word;
  logic             wr_fire;
  logic             tick;
  logic [6:0]       pre_half;
  logic [4:0]       nbits;
  logic [4:0]       total;
  logic [5:0]       trans_total;
  logic [5:0]       k;
  logic             ph_eff;
  logic             pol_eff;
  logic             cap_evt;
  logic [15:0]      load_word;
  logic [15:0]      load_sh;
  logic [15:0]      size_mask;
  logic             master_on;
  logic             rise;
  logic             fall;
  logic             lead;
  logic             trail;
  logic             to_set;
  logic             ov_set;

  // ==========================================================
  // buffers
  ssp_fifo #(.WIDTH(DATA_W), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .clk      (clk),
    .reset    (reset),
    .in_valid (wr_valid),
    .in_ready (wr_ready),
    .in_data  (wr_data),
    .out_valid(tx_valid),
    .out_ready(tx_pop),
    .out_data (tx_word)
  );

  ssp_fifo #(.WIDTH(DATA_W), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .clk      (clk),
    .reset    (reset),
    .in_valid (rx_push),
    .in_ready (rx_ready),
    .in_data  (rx_word),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data (rd_data)
  );

  // ==========================================================
  // derived values
  assign wr_fire     = wr_valid && wr_ready;
  assign master_on   = cfg.enable && !cfg.slave_mode;
  assign nbits       = (cfg.size_m1 < SIZE_MIN_M1) ? 5'h04 : 5'(cfg.size_m1 + 1'b1);
  assign total       = (cfg.format == FMT_CTRL) ? 5'(CTRL_HEAD + nbits) : nbits;
  assign trans_total = {total, 1'b0};
  assign ph_eff      = (cfg.format == FMT_PULSE) ? 1'b1 :
                       (cfg.format == FMT_CTRL) ? 1'b0 : cfg.clock_phase_bit;
  assign pol_eff     = (cfg.format == FMT_SPI) ? cfg.clock_polarity_bit : 1'b0;
  assign size_mask   = 16'((17'h0_0001 << nbits) - 1'b1);
  assign rx_word     = st_r.rxsh & size_mask;
  // the slave falls back on the oldest of the last eight written words
  assign load_word   = tx_valid ? tx_word :
                       (st_r.hist_cnt == HIST_FULL) ? st_r.hist[st_r.hist_ptr] : 16'h0000;
  assign load_sh     = (cfg.format == FMT_CTRL) ? {load_word[7:0], 8'h00} :
                       16'(load_word << (5'h10 - nbits));
  // clock divider: half of the even prescale, then one plus the rate field
  assign pre_half    = (cfg.prescale_divisor < PRESCALE_MIN) ? 7'h01 :
                       cfg.prescale_divisor[7:1];
  assign rise        = st_r.s_clk[1] && !st_r.clk_d;
  assign fall        = !st_r.s_clk[1] && st_r.clk_d;
  assign lead        = pol_eff ? fall : rise;
  assign trail       = pol_eff ? rise : fall;

  // ==========================================================
  // next state
  always_comb
  begin
    st_nxt  = st_r;
    tick    = 1'b0;
    tx_pop  = 1'b0;
    rx_push = 1'b0;
    to_set  = 1'b0;
    ov_set  = 1'b0;
    k       = 6'(st_r.trans + 1'b1);
    cap_evt = (k[0] == !ph_eff);

    st_nxt.s_clk = {st_r.s_clk[0], serial_clock_pin_i};
    st_nxt.s_fss = {st_r.s_fss[0], frame_select_pin_i};
    st_nxt.s_rx  = {st_r.s_rx[0], serial_receive_pin};
    st_nxt.clk_d = st_r.s_clk[1];

    if (!cfg.enable)
    begin
      st_nxt.pre_cnt = '0;
      st_nxt.scr_cnt = '0;
    end
    else if (7'(st_r.pre_cnt + 1'b1) >= pre_half)
    begin
      st_nxt.pre_cnt = '0;
      if (st_r.scr_cnt >= cfg.serial_clock_rate_field)
      begin
        st_nxt.scr_cnt = '0;
        tick           = 1'b1;
      end
      else
      begin
        st_nxt.scr_cnt = 8'(st_r.scr_cnt + 1'b1);
      end
    end
    else
    begin
      st_nxt.pre_cnt = 7'(st_r.pre_cnt + 1'b1);
    end

    if (!cfg.enable)
    begin
      st_nxt.st       = ST_IDLE;
      st_nxt.sl_act   = 1'b0;
      st_nxt.hist_cnt = '0;
    end
    else if (!cfg.slave_mode)
    begin
      unique case (st_r.st)
        ST_IDLE:
        begin
          st_nxt.sclk = pol_eff;
          st_nxt.fss  = (cfg.format != FMT_PULSE);
          st_nxt.txd  = 1'b0;
          st_nxt.txoe = (cfg.format != FMT_PULSE);
          if (tick && tx_valid)
          begin
            tx_pop        = 1'b1;
            st_nxt.txsh   = load_sh;
            st_nxt.trans  = '0;
            st_nxt.caps   = '0;
            st_nxt.txoe   = 1'b1;
            if (cfg.format == FMT_PULSE)
            begin
              st_nxt.st   = ST_PRE;
              st_nxt.fss  = 1'b1;
              st_nxt.sclk = 1'b1;
            end
            else
            begin
              st_nxt.st  = ST_SHIFT;
              st_nxt.fss = 1'b0;
              st_nxt.txd = ph_eff ? 1'b0 : load_sh[15];
            end
          end
        end
        ST_PRE:
        begin
          if (tick)
          begin
            st_nxt.sclk = 1'b0;
            st_nxt.st   = ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (tick)
          begin
            st_nxt.sclk  = !st_r.sclk;
            st_nxt.trans = k;
            if (cfg.format == FMT_PULSE && k == 6'h01)
            begin
              st_nxt.fss = 1'b0;
            end
            if (cap_evt)
            begin
              st_nxt.caps = 5'(st_r.caps + 1'b1);
              if (cfg.format != FMT_CTRL || st_r.caps >= CTRL_HEAD)
              begin
                st_nxt.rxsh = {st_r.rxsh[14:0], st_r.s_rx[1]};
              end
            end
            else if (ph_eff && k == 6'h01)
            begin
              st_nxt.txd = st_r.txsh[15];
            end
            else
            begin
              st_nxt.txsh = {st_r.txsh[14:0], 1'b0};
              st_nxt.txd  = st_r.txsh[14];
            end
            if (k == trans_total)
            begin
              st_nxt.st = ST_TAIL;
            end
          end
        end
        ST_TAIL:
        begin
          if (tick)
          begin
            rx_push     = 1'b1;
            ov_set      = !rx_ready;
            st_nxt.st   = ST_IDLE;
            st_nxt.sclk = pol_eff;
            st_nxt.fss  = (cfg.format != FMT_PULSE);
            st_nxt.txd  = 1'b0;
            st_nxt.txoe = (cfg.format != FMT_PULSE);
          end
        end
      endcase
    end
    else
    begin
      st_nxt.st   = ST_IDLE;
      st_nxt.txoe = st_r.sl_act;
      if (cfg.format != FMT_PULSE && st_r.s_fss[1])
      begin
        st_nxt.sl_act = 1'b0;
        st_nxt.txoe   = 1'b0;
      end
      else if ((cfg.format != FMT_PULSE && !st_r.sl_act) ||
               (cfg.format == FMT_PULSE && fall && st_r.s_fss[1]))
      begin
        tx_pop          = tx_valid;
        st_nxt.txsh     = load_sh;
        st_nxt.txd      = ph_eff ? 1'b0 : load_sh[15];
        st_nxt.sl_act   = 1'b1;
        st_nxt.sl_first = 1'b1;
        st_nxt.caps     = '0;
      end
      else if (st_r.sl_act && st_r.caps < nbits)
      begin
        if (ph_eff ? trail : lead)
        begin
          st_nxt.rxsh = {st_r.rxsh[14:0], st_r.s_rx[1]};
          st_nxt.caps = 5'(st_r.caps + 1'b1);
          if (5'(st_r.caps + 1'b1) == nbits)
          begin
            rx_push = 1'b1;
            ov_set  = !rx_ready;
            if (cfg.format == FMT_PULSE)
            begin
              st_nxt.sl_act = 1'b0;
            end
            else if (ph_eff)
            begin
              st_nxt.sl_act = 1'b0;
            end
          end
        end
        else if (ph_eff ? lead : trail)
        begin
          if (ph_eff && st_r.sl_first)
          begin
            st_nxt.sl_first = 1'b0;
            st_nxt.txd      = st_r.txsh[15];
          end
          else
          begin
            st_nxt.txsh = {st_r.txsh[14:0], 1'b0};
            st_nxt.txd  = st_r.txsh[14];
          end
        end
      end
    end

    if (cfg.enable && wr_fire)
    begin
      st_nxt.hist[st_r.hist_ptr] = wr_data;
      st_nxt.hist_ptr            = 3'(st_r.hist_ptr + 1'b1);
      if (st_r.hist_cnt != HIST_FULL)
      begin
        st_nxt.hist_cnt = 4'(st_r.hist_cnt + 1'b1);
      end
    end

    // timeout counts idle half periods while received words wait
    if (!master_on || st_r.st != ST_IDLE || !rd_valid || rd_ready || tx_valid)
    begin
      st_nxt.to_cnt = '0;
    end
    else if (tick && st_r.to_cnt != TIMEOUT_HALF)
    begin
      st_nxt.to_cnt = 7'(st_r.to_cnt + 1'b1);
      to_set        = (7'(st_r.to_cnt + 1'b1) == TIMEOUT_HALF);
    end
    st_nxt.to_flag = to_set || (st_r.to_flag && !timeout_clear);
    st_nxt.ov_flag = ov_set || (st_r.ov_flag && !overrun_clear);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign raw_interrupt_status[IRQ_TX]      = !tx_valid;
  assign raw_interrupt_status[IRQ_RX]      = rd_valid;
  assign raw_interrupt_status[IRQ_TIMEOUT] = st_r.to_flag;
  assign raw_interrupt_status[IRQ_OVERRUN] = st_r.ov_flag;
  assign masked_interrupt_status = raw_interrupt_status & interrupt_mask;
  assign irq                     = |masked_interrupt_status;
  assign dma_tx_req              = dma_tx_enable && !tx_valid;
  assign dma_rx_req              = dma_rx_enable && rd_valid;
  assign busy                    = (st_r.st != ST_IDLE) || st_r.sl_act;
  assign serial_clock_pin_o      = st_r.sclk;
  assign serial_clock_pin_oe     = master_on;
  assign frame_select_pin_o      = st_r.fss;
  assign frame_select_pin_oe     = master_on;
  assign serial_transmit_pin     = st_r.txd;
  assign serial_transmit_pin_oe  = cfg.enable && st_r.txoe;
endmodule

// file: ssp_pkg.sv
// constants, types and carriers of the synchronous serial port
// Overview of operation
// - prescale divides system clock by even 2..254
// - second divide by one plus rate field
// - transmit fifo 16 bits by 8, write pushes
// - slave underrun sends eighth latest word or zero
// - transmit fifo empty raises service and dma
// - receive fifo 16 bits by 8, read pops
// - four sources ored into one request
// - per-source mask bit, one enables it
// - raw and masked status both readable
// - frames 4..16 bits, msb first
// - serial clock idles inactive, toggles when active
// - timeout in master mode when clock idle with receive data
// - spi and control formats frame low throughout
// - pulse framing: drive rising, latch falling
// - control format sends 8-bit word, ignores receive during it
// - pulse format idles clock, frame low, transmit off
// - pulse frame high one period, load shifter
// - msb out next rising, sample on falling
// - received word stored after last bit sampled in master; slave stores it as the last bit is sampled, without that bit
// - polarity bit sets idle clock level
// - phase bit picks first or second edge
package ssp_pkg;

  localparam int DATA_W     = 16;
  localparam int TX_DEPTH   = 8;
  localparam int RX_DEPTH   = 8;
  localparam int HIST_DEPTH = 8;

  localparam logic [7:0] PRESCALE_MIN = 8'h02;
  localparam logic [3:0] SIZE_MIN_M1  = 4'h3;
  localparam logic [4:0] CTRL_HEAD    = 5'h09;
  localparam logic [4:0] CTRL_BITS    = 5'h08;
  localparam logic [3:0] HIST_FULL    = 4'h8;
  localparam logic [6:0] TIMEOUT_HALF = 7'h40;

  localparam logic [1:0] FMT_SPI   = 2'h0;
  localparam logic [1:0] FMT_PULSE = 2'h1;
  localparam logic [1:0] FMT_CTRL  = 2'h2;

  localparam int IRQ_TX      = 0;
  localparam int IRQ_RX      = 1;
  localparam int IRQ_TIMEOUT = 2;
  localparam int IRQ_OVERRUN = 3;

  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_SHIFT, ST_TAIL} ssp_state_e;

  typedef struct packed {
    logic       enable;
    logic       slave_mode;
    logic [1:0] format;
    logic [3:0] size_m1;
    logic       clock_polarity_bit;
    logic       clock_phase_bit;
    logic [7:0] prescale_divisor;
    logic [7:0] serial_clock_rate_field;
  } ssp_cfg_s;

  typedef struct packed {
    ssp_state_e                          st;
    logic [6:0]                          pre_cnt;
    logic [7:0]                          scr_cnt;
    logic [5:0]                          trans;
    logic [4:0]                          caps;
    logic [15:0]                         txsh;
    logic [15:0]                         rxsh;
    logic                                sclk;
    logic                                fss;
    logic                                txd;
    logic                                txoe;
    logic [1:0]                          s_clk;
    logic [1:0]                          s_fss;
    logic [1:0]                          s_rx;
    logic                                clk_d;
    logic                                sl_act;
    logic                                sl_first;
    logic [6:0]                          to_cnt;
    logic                                to_flag;
    logic                                ov_flag;
    logic [2:0]                          hist_ptr;
    logic [3:0]                          hist_cnt;
    logic [HIST_DEPTH-1:0][DATA_W-1:0]   hist;
  } ssp_state_s;

endpackage

// file: ssp_sync_serial_port_sva.sv
// concurrent checks on the serial port top ports
`timescale 1ns/10ps
module ssp_sync_serial_port_sva
  import ssp_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire ssp_cfg_s   cfg,
  input wire logic [3:0] interrupt_mask,
  input wire logic       overrun_clear,
  input wire logic       dma_tx_enable,
  input wire logic       dma_rx_enable,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic       rd_valid,
  input wire logic [3:0] raw_interrupt_status,
  input wire logic [3:0] masked_interrupt_status,
  input wire logic       irq,
  input wire logic       dma_tx_req,
  input wire logic       dma_rx_req,
  input wire logic       serial_clock_pin_o,
  input wire logic       frame_select_pin_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // helper: cycles since the last clock or frame line event
  logic [15:0] gap_r;
  wire logic        spi_m = cfg.enable && !cfg.slave_mode && cfg.format == FMT_SPI;
  wire logic [15:0] half_w = {9'h000, cfg.prescale_divisor[7:1]} *
                             ({8'h00, cfg.serial_clock_rate_field} + 16'h0001);
  always_ff @(posedge clk)
  begin
    if (reset || $changed(serial_clock_pin_o) || $changed(frame_select_pin_o))
      gap_r <= 16'h0000;
    else if (gap_r != 16'hFFFF)
      gap_r <= gap_r + 16'h0001;
  end
  // ==========================================================
  // assertions
  chk_irq_combine: assert property (irq == |(raw_interrupt_status & interrupt_mask))
    else $error("combined request differs from masked sources");
  chk_mask_apply: assert property (masked_interrupt_status == (raw_interrupt_status & interrupt_mask))
    else $error("masked status differs from raw and mask");
  chk_dma_tx_empty: assert property (dma_tx_req == (dma_tx_enable && raw_interrupt_status[IRQ_TX]))
    else $error("transmit dma request wrong");
  chk_rx_service: assert property ((raw_interrupt_status[IRQ_RX] == rd_valid) &&
    (dma_rx_req == (dma_rx_enable && rd_valid))) else $error("receive service wrong");
  chk_push_fills: assert property (wr_valid && wr_ready |=> !raw_interrupt_status[IRQ_TX])
    else $error("push left transmit empty");
  chk_idle_level: assert property (spi_m && frame_select_pin_o && $past(frame_select_pin_o) &&
    $past(cfg, 2) == cfg |-> serial_clock_pin_o == cfg.clock_polarity_bit)
    else $error("idle clock not at polarity level");
  chk_frame_low: assert property (!$past(reset) && spi_m && $changed(serial_clock_pin_o) &&
    $past(cfg, 2) == cfg |-> !frame_select_pin_o) else $error("clock moved outside frame");
  chk_half_period: assert property (!$past(reset) && spi_m && $changed(serial_clock_pin_o) &&
    !frame_select_pin_o |-> gap_r == half_w - 16'h0001) else $error("clock half period wrong");
  chk_overrun_sticky: assert property ($fell(raw_interrupt_status[IRQ_OVERRUN]) |->
    $past(overrun_clear)) else $error("overrun flag dropped without clear");
  cover property (spi_m && serial_clock_pin_o && !frame_select_pin_o);
  cover property (raw_interrupt_status[IRQ_OVERRUN]);
  cover property (raw_interrupt_status[IRQ_TIMEOUT]);
endmodule

bind ssp_sync_serial_port ssp_sync_serial_port_sva u_sva (.clk, .reset, .cfg, .interrupt_mask,
  .overrun_clear, .dma_tx_enable, .dma_rx_enable, .wr_valid, .wr_ready, .rd_valid,
  .raw_interrupt_status, .masked_interrupt_status, .irq, .dma_tx_req, .dma_rx_req,
  .serial_clock_pin_o, .frame_select_pin_o);

// file: ssp_spi_peer_model.sv
// behavioural spi peripheral facing the port in master mode
`timescale 1ns/10ps
module ssp_spi_peer_model (
  input  wire logic        sclk,
  input  wire logic        fss_n,
  input  wire logic        mosi,
  input  wire logic        cpol,
  input  wire logic        cpha,
  input  wire logic [4:0]  nbits,
  input  wire logic [15:0] reply,
  output logic             miso,
  output logic [15:0]      got
);
  int idx;
  initial
  begin
    miso = 1'b0;
    got = 16'h0000;
    idx = 0;
  end
  // frame start loads the reply, phase 0 shows its msb at once
  always @(negedge fss_n)
  begin
    got = 16'h0000;
    idx = nbits;
    if (!cpha)
    begin
      idx = idx - 1;
      miso = reply[idx];
    end
  end
  // a deselected line does not keep the last bit
  always @(posedge fss_n)
    miso = ~miso;
  always @(sclk)
  begin
    if (!fss_n)
    begin
      if ((sclk != cpol) ^ cpha)
        got = {got[14:0], mosi};
      else if (idx > 0)
      begin
        idx = idx - 1;
        miso = reply[idx];
      end
    end
  end
endmodule

// file: tb_ssp_sync_serial_port.sv
// self-checking bench for the serial port as spi master
`timescale 1ns/10ps
module tb_ssp_sync_serial_port;
  import ssp_pkg::*;
  // half period in clocks: prescale 4 / 2 times (1 + rate 1)
  localparam int HALF = 4;
  logic        clk;
  logic        reset;
  ssp_cfg_s    cfg;
  logic [3:0]  mask;
  logic        to_clr;
  logic        ov_clr;
  logic        wr_valid;
  logic        wr_ready;
  logic        rd_valid;
  logic        rd_ready;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [3:0]  raw;
  logic        irq;
  logic        busy;
  logic        sclk;
  logic        fss;
  logic        miso;
  logic        mosi;
  logic [4:0]  nbits;
  logic [15:0] reply;
  logic [15:0] got;
  logic [1:0]  dma_en;
  wire  [2:0]  oe;
  int          miscompares;
  int          cmp_count;
  ssp_sync_serial_port dut (.clk(clk), .reset(reset), .cfg(cfg), .interrupt_mask(mask),
    .timeout_clear(to_clr), .overrun_clear(ov_clr), .dma_tx_enable(dma_en[0]),
    .dma_rx_enable(dma_en[1]),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .raw_interrupt_status(raw),
    .masked_interrupt_status(), .irq(irq), .dma_tx_req(), .dma_rx_req(), .busy(busy),
    .serial_clock_pin_i(1'b0), .serial_clock_pin_o(sclk), .serial_clock_pin_oe(oe[2]),
    .frame_select_pin_i(1'b1), .frame_select_pin_o(fss), .frame_select_pin_oe(oe[1]),
    .serial_receive_pin(miso), .serial_transmit_pin(mosi), .serial_transmit_pin_oe(oe[0]));
  ssp_spi_peer_model peer (.sclk(sclk), .fss_n(fss), .mosi(mosi), .cpol(cfg.clock_polarity_bit),
    .cpha(cfg.clock_phase_bit), .nbits(nbits), .reply(reply), .miso(miso), .got(got));
  // ==========================================================
  // shared tasks
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask
  task automatic bound(input int n);
    if (n >= 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge clk);
    while ((busy !== 1'b0 || raw[IRQ_TX] !== 1'b1) && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    bound(n);
    repeat (2) @(negedge clk);
  endtask
  task automatic push_words(input int cnt, input logic [15:0] base);
    int n;
    wr_valid = 1'b1;
    for (int i = 0; i < cnt; i++)
    begin
      wr_data = base + 16'(i);
      n = 0;
      while (wr_ready !== 1'b1 && n < 5000)
      begin
        @(negedge clk);
        n++;
      end
      bound(n);
      @(negedge clk);
    end
    wr_valid = 1'b0;
  endtask
  task automatic pop_words(input int cnt, input logic [15:0] exp);
    int n;
    rd_ready = 1'b1;
    for (int i = 0; i < cnt; i++)
    begin
      n = 0;
      while (rd_valid !== 1'b1 && n < 5000)
      begin
        @(negedge clk);
        n++;
      end
      bound(n);
      check("rd_data", exp, rd_data);
      @(negedge clk);
    end
    rd_ready = 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    check("wr_ready", 16'h0001, {15'h0000, wr_ready});
    check("rd_valid", 16'h0000, {15'h0000, rd_valid});
    check("raw status", 16'h0001, {12'h000, raw});
    check("frame idle", 16'h0001, {15'h0000, fss});
    check("clock idle", 16'h0000, {15'h0000, sclk});
    check("pin enables", 16'h0007, {13'h0000, oe});
  endtask
  task automatic t_spi_mode(input logic [1:0] m, input logic [4:0] sz);
    logic [15:0] keep;
    logic [15:0] w;
    keep = 16'hFFFF >> (5'h10 - sz);
    w = 16'h9B6E ^ {12'h000, m, 2'h0};
    cfg.clock_polarity_bit = m[1];
    cfg.clock_phase_bit = m[0];
    cfg.size_m1 = 4'(sz - 5'h01);
    nbits = sz;
    reply = 16'hA5C3 ^ {14'h0000, m};
    repeat (3) @(negedge clk);
    check("idle clock", {15'h0000, m[1]}, {15'h0000, sclk});
    push_words(1, w);
    pop_words(1, reply & keep);
    wait_idle();
    check("peer capture", w & keep, got & keep);
  endtask
  task automatic t_fifo_overrun();
    cfg.enable = 1'b0;
    repeat (2) @(negedge clk);
    check("pins off", 16'h0000, {13'h0000, oe});
    push_words(8, 16'h1230);
    check("wr_ready full", 16'h0000, {15'h0000, wr_ready});
    check("tx service", 16'h0000, {15'h0000, raw[IRQ_TX]});
    cfg.enable = 1'b1;
    wait_idle();
    push_words(1, 16'h4321);
    wait_idle();
    check("overrun", 16'h0001, {15'h0000, raw[IRQ_OVERRUN]});
    mask = 4'h8;
    @(negedge clk);
    check("irq on", 16'h0001, {15'h0000, irq});
    mask = 4'h0;
    @(negedge clk);
    check("irq masked", 16'h0000, {15'h0000, irq});
    ov_clr = 1'b1;
    @(negedge clk);
    ov_clr = 1'b0;
    @(negedge clk);
    check("overrun clear", 16'h0000, {15'h0000, raw[IRQ_OVERRUN]});
    pop_words(8, reply & 16'h00FF);
    check("rx drained", 16'h0000, {15'h0000, rd_valid});
  endtask
  task automatic t_timeout();
    dma_en = 2'h2;
    to_clr = 1'b1;
    @(negedge clk);
    to_clr = 1'b0;
    push_words(1, 16'h0F0F);
    wait_idle();
    repeat (56 * HALF) @(negedge clk);
    check("timeout early", 16'h0000, {15'h0000, raw[IRQ_TIMEOUT]});
    repeat (16 * HALF) @(negedge clk);
    check("timeout set", 16'h0001, {15'h0000, raw[IRQ_TIMEOUT]});
    to_clr = 1'b1;
    @(negedge clk);
    to_clr = 1'b0;
    check("timeout clear", 16'h0000, {15'h0000, raw[IRQ_TIMEOUT]});
    pop_words(1, reply & 16'h00FF);
  endtask
  // control word of 8 bits, a wait slot, then 4 reply bits: 13-bit frame
  task automatic t_ctrl_frame();
    cfg.format = FMT_CTRL;
    cfg.size_m1 = 4'h3;
    nbits = 5'h0D;
    reply = 16'h1FF6;
    repeat (3) @(negedge clk);
    push_words(1, 16'hC3B5);
    pop_words(1, 16'h0006);
    wait_idle();
    check("control word", 16'h16A0, got);
  endtask
  // ==========================================================
  // clock and main sequence
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    reset = 1'b1;
    cfg = '{enable: 1'b1, slave_mode: 1'b0, format: FMT_SPI, size_m1: 4'h7,
      clock_polarity_bit: 1'b0, clock_phase_bit: 1'b0, prescale_divisor: 8'h04,
      serial_clock_rate_field: 8'h01};
    {mask, to_clr, ov_clr, wr_valid, rd_ready, wr_data} = '0;
    dma_en = 2'h1;
    nbits = 5'h08;
    reply = 16'h0000;
    miscompares = 0;
    cmp_count = 0;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    t_reset();
    t_spi_mode(2'h0, 5'h04);
    t_spi_mode(2'h1, 5'h10);
    t_spi_mode(2'h2, 5'h08);
    t_spi_mode(2'h3, 5'h0C);
    t_spi_mode(2'h0, 5'h08);
    t_fifo_overrun();
    t_timeout();
    t_ctrl_frame();
    tally_and_finish();
  end
endmodule
